// [hdl/rfc_regs.v]
`timescale 1ns/100ps
`default_nettype none
`include "rfc_defines.vh"
// Notes on behaviour
// - bit 7 of tx_bit_timing set selects the RF field as demodulator clock source.
// - bits 6..0 of tx_bit_timing add that many carrier cycles before every transmission.
// - bit 7 of rf_receive_config enables the level detector amplifier.
// - bits 6..4 of rf_receive_config select gain 18,23,18,23,33,38,43,48 dB.
// - bits 3..0 of rf_receive_config set level detector sensitivity.
// - unmodulated N conductance comes from the on register only while a driver is on.
// - modulated N conductance comes from the on register only while a driver is on.
// - conductance fields are binary weighted values passed as plain binary.
// - in soft power-down the top bit of each conductance field is forced to 1.
// - p_drive_unmod sets the P-driver conductance without modulation.
// - bits 7 and 6 of p_driver_cw_conductance read as zero.
// - the driver-off N register at index 23h resets to 88h, unmod high nibble, mod low.
module rfc_regs (
   input wire mclk,
   input wire rstn,
   input wire [7:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   input wire [3:0] avs_byteenable,
   output reg [31:0] avs_readdata,
   output reg avs_waitrequest,
   input wire tx_request,
   output reg tx_send_go,
   output reg demod_clock_source_sel,
   output reg level_detect_amp_en,
   output reg [2:0] receiver_gain_sel,
   output reg [5:0] receiver_gain_db,
   output reg [3:0] level_detect_sensitivity,
   output reg [3:0] n_drive_cond,
   output reg [5:0] p_drive_unmod,
   output reg antenna_driver_1,
   output reg antenna_driver_2,
   output reg soft_power_down
);
   // ************************************************
   // register storage
   // ************************************************
   reg [7:0] n_off_q;
   reg [7:0] tx_timing_q;
   reg [7:0] rx_cfg_q;
   reg [7:0] n_on_q;
   reg [5:0] p_cw_q;
   reg [7:0] ctrl_q;
   reg ack_q;
   wire [7:0] idx;
   wire hit_wr;
   wire go;

   // byte address is four times the index; low two bits must be zero
   assign idx = {2'b00, avs_address[7:2]};
   assign hit_wr = avs_write && avs_byteenable[0] && !ack_q;

   // gain code to dB
   function [5:0] gain_db;
      input [2:0] code;
      begin
         case (code)
            3'h0: gain_db = 6'd18;
            3'h1: gain_db = 6'd23;
            3'h2: gain_db = 6'd18;
            3'h3: gain_db = 6'd23;
            3'h4: gain_db = 6'd33;
            3'h5: gain_db = 6'd38;
            3'h6: gain_db = 6'd43;
            default: gain_db = 6'd48;
         endcase
      end
   endfunction

   // force top bit in power-down
   function [3:0] nib_pd;
      input [3:0] v;
      input pd;
      begin
         nib_pd = {v[3] | pd, v[2:0]};
      end
   endfunction

   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         n_off_q <= `RFC_RST_N_OFF;
         tx_timing_q <= `RFC_RST_TX_TIMING;
         rx_cfg_q <= `RFC_RST_RX_CFG;
         n_on_q <= `RFC_RST_N_ON;
         p_cw_q <= 6'h20;
         ctrl_q <= `RFC_RST_CTRL;
      end else if (hit_wr && avs_address[1:0] == 2'b00) begin
         case (idx)
            `RFC_IDX_N_OFF: n_off_q <= avs_writedata[7:0];
            `RFC_IDX_TX_TIMING: tx_timing_q <= avs_writedata[7:0];
            `RFC_IDX_RX_CFG: rx_cfg_q <= avs_writedata[7:0];
            `RFC_IDX_N_ON: n_on_q <= avs_writedata[7:0];
            `RFC_IDX_P_CW: p_cw_q <= avs_writedata[5:0];
            `RFC_IDX_CTRL: ctrl_q <= {4'h0, avs_writedata[3:0]};
            default: ctrl_q <= ctrl_q;
         endcase
      end
   end

   // ************************************************
   // avalon slave: one wait cycle, then answer
   // ************************************************
   reg [7:0] rd_byte;
   always @* begin
      rd_byte = 8'h00;
      if (avs_address[1:0] == 2'b00) begin
         case (idx)
            `RFC_IDX_N_OFF: rd_byte = n_off_q;
            `RFC_IDX_TX_TIMING: rd_byte = tx_timing_q;
            `RFC_IDX_RX_CFG: rd_byte = rx_cfg_q;
            `RFC_IDX_N_ON: rd_byte = n_on_q;
            `RFC_IDX_P_CW: rd_byte = {2'b00, p_cw_q};
            `RFC_IDX_CTRL: rd_byte = ctrl_q;
            default: rd_byte = 8'h00;
         endcase
      end
   end

   assign go = (avs_read || avs_write) && !ack_q;

   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         ack_q <= 1'b0;
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h0000_0000;
      end else begin
         ack_q <= go;
         avs_waitrequest <= !go;
         if (go) begin
            avs_readdata <= {24'h000000, rd_byte};
         end
      end
   end

   // ************************************************
   // transmit wait extension
   // ************************************************
   wire send_go_w;
   rfc_tx_delay #(
      .W(7)
   ) u_delay (
      .mclk(mclk),
      .rstn(rstn),
      .start(tx_request),
      .extra(tx_timing_q[6:0]),
      .send_go(send_go_w)
   );

   // ************************************************
   // analog control outputs
   // ************************************************
   wire drv_on;
   wire pd;
   wire [3:0] n_sel;
   assign drv_on = ctrl_q[`RFC_CTRL_DRV1_BIT] | ctrl_q[`RFC_CTRL_DRV2_BIT];
   assign pd = ctrl_q[`RFC_CTRL_PDOWN_BIT];
   // on/off and unmod/mod choice
   assign n_sel = ctrl_q[`RFC_CTRL_MOD_BIT] ?
      (drv_on ? n_on_q[3:0] : n_off_q[3:0]) :
      (drv_on ? n_on_q[7:4] : n_off_q[7:4]);

   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         tx_send_go <= 1'b0;
         demod_clock_source_sel <= 1'b1;
         level_detect_amp_en <= 1'b0;
         receiver_gain_sel <= 3'h4;
         receiver_gain_db <= 6'd33;
         level_detect_sensitivity <= 4'h8;
         n_drive_cond <= 4'h8;
         p_drive_unmod <= 6'h20;
         antenna_driver_1 <= 1'b0;
         antenna_driver_2 <= 1'b0;
         soft_power_down <= 1'b0;
      end else begin
         tx_send_go <= send_go_w;
         demod_clock_source_sel <= tx_timing_q[`RFC_DEMOD_SEL_BIT];
         level_detect_amp_en <= rx_cfg_q[`RFC_LVL_AMP_BIT];
         receiver_gain_sel <= rx_cfg_q[6:4];
         receiver_gain_db <= gain_db(rx_cfg_q[6:4]);
         level_detect_sensitivity <= rx_cfg_q[3:0];
         n_drive_cond <= nib_pd(n_sel, pd);
         p_drive_unmod <= {p_cw_q[5] | pd, p_cw_q[4:0]};
         antenna_driver_1 <= ctrl_q[`RFC_CTRL_DRV1_BIT];
         antenna_driver_2 <= ctrl_q[`RFC_CTRL_DRV2_BIT];
         soft_power_down <= pd;
      end
   end
endmodule // rfc_regs
`default_nettype wire

// [hdl/rfc_defines.vh]
`ifndef RFC_DEFINES_VH
`define RFC_DEFINES_VH
// register indices (byte address is four times the index)
`define RFC_IDX_N_OFF 8'h23
`define RFC_IDX_TX_TIMING 8'h25
`define RFC_IDX_RX_CFG 8'h26
`define RFC_IDX_N_ON 8'h27
`define RFC_IDX_P_CW 8'h28
`define RFC_IDX_CTRL 8'h30
// reset values
`define RFC_RST_N_OFF 8'h88
`define RFC_RST_TX_TIMING 8'h87
`define RFC_RST_RX_CFG 8'h48
`define RFC_RST_N_ON 8'h88
`define RFC_RST_P_CW 8'h20
`define RFC_RST_CTRL 8'h00
// field positions
`define RFC_DEMOD_SEL_BIT 7
`define RFC_LVL_AMP_BIT 7
`define RFC_P_MASK 8'h3F
// control register bits
`define RFC_CTRL_DRV1_BIT 0
`define RFC_CTRL_DRV2_BIT 1
`define RFC_CTRL_MOD_BIT 2
`define RFC_CTRL_PDOWN_BIT 3
// bus read latency in cycles after the request is seen
`define RFC_RD_WAIT 1
`endif

// [hdl/rfc_tx_delay.v]
`timescale 1ns/100ps
`default_nettype none
// ************************************************
// transmit wait extension counter
// ************************************************
module rfc_tx_delay #(
   parameter W = 7
) (
   input wire mclk,
   input wire rstn,
   input wire start,
   input wire [W-1:0] extra,
   output reg send_go
);
   reg [W-1:0] cnt_q;
   reg busy_q;
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         cnt_q <= {W{1'b0}};
         busy_q <= 1'b0;
         send_go <= 1'b0;
      end else begin
         send_go <= 1'b0;
         if (start && !busy_q) begin
            if (extra == {W{1'b0}}) begin
               send_go <= 1'b1;
            end else begin
               cnt_q <= extra;
               busy_q <= 1'b1;
            end
         end else if (busy_q) begin
            if (cnt_q == {{(W-1){1'b0}}, 1'b1}) begin
               busy_q <= 1'b0;
               send_go <= 1'b1;
            end
            cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
         end
      end
   end
endmodule // rfc_tx_delay
`default_nettype wire

// [test/rfc_regs_properties.sv]
`timescale 1ns/100ps
`default_nettype none
// ****************
// port checks
// ****************
module rfc_regs_properties (
   input wire mclk,
   input wire rstn,
   input wire [7:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   input wire [3:0] avs_byteenable,
   input wire [31:0] avs_readdata,
   input wire avs_waitrequest,
   input wire demod_clock_source_sel,
   input wire level_detect_amp_en,
   input wire [2:0] receiver_gain_sel,
   input wire [5:0] receiver_gain_db,
   input wire [3:0] level_detect_sensitivity,
   input wire [3:0] n_drive_cond,
   input wire [5:0] p_drive_unmod,
   input wire soft_power_down
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   sequence ask;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence wr_at(a);
      avs_write && !avs_waitrequest && avs_byteenable[0] && avs_address == a;
   endsequence
   AST_ANSWER: assert property (ask |-> ##[1:2] !avs_waitrequest)
      else $error("no bus answer");
   AST_PULSE: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("wait low too long");
   AST_DEMOD: assert property (wr_at(8'h94) |-> ##2
      demod_clock_source_sel == $past(avs_writedata[7], 2)) else $error("demod select");
   AST_RXCFG: assert property (wr_at(8'h98) |-> ##2
      {level_detect_amp_en, receiver_gain_sel, level_detect_sensitivity}
      == $past(avs_writedata[7:0], 2)) else $error("rx config");
   AST_GAIN_DB: assert property (receiver_gain_db == (receiver_gain_sel[2] ?
      6'h21 + 6'h05 * {4'h0, receiver_gain_sel[1:0]} : (receiver_gain_sel[0] ? 6'h17 : 6'h12)))
      else $error("gain db");
   AST_PDOWN: assert property (soft_power_down |-> n_drive_cond[3] && p_drive_unmod[5])
      else $error("power down force");
   AST_RSVD: assert property (avs_read && !avs_waitrequest && avs_address == 8'hA0
      |-> avs_readdata[31:6] == 26'h0) else $error("reserved bits");
   AST_P: assert property (wr_at(8'hA0) |-> ##2
      p_drive_unmod == ($past(avs_writedata[5:0], 2) | {soft_power_down, 5'h00}))
      else $error("p conductance");
endmodule // rfc_regs_properties
`default_nettype wire

// [test/rf_frontend_config_regs_tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
// ****************
// register bank bench
// ****************
module rf_frontend_config_regs_tb_top;
   logic mclk, rstn, avs_read, avs_write, tx_request, tx_send_go, avs_waitrequest;
   logic demod_clock_source_sel, level_detect_amp_en, antenna_driver_1, antenna_driver_2;
   logic soft_power_down;
   logic [7:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, q;
   logic [3:0] avs_byteenable, n_drive_cond, level_detect_sensitivity, nx;
   logic [2:0] receiver_gain_sel;
   logic [5:0] receiver_gain_db, p_drive_unmod;
   integer failures = 0, total_checks = 0, i, k;
   logic [7:0] adr [6] = '{8'h8C, 8'h94, 8'h98, 8'h9C, 8'hA0, 8'hC0};
   logic [7:0] rst [6] = '{8'h88, 8'h87, 8'h48, 8'h88, 8'h20, 8'h00};
   logic [5:0] db [8] = '{6'h12, 6'h17, 6'h12, 6'h17, 6'h21, 6'h26, 6'h2B, 6'h30};
   integer nv [3] = '{0, 5, 127};
   rfc_regs rfc_regs_inst (.*);
   task chk(input string n, input [31:0] e, input [31:0] g);
      total_checks++;
      if (g !== e) begin
         failures++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task bus(input w, input [7:0] a, input [7:0] d, input be);
      integer n;
      avs_address <= a;
      avs_writedata <= {24'h000000, d};
      avs_byteenable <= {3'h0, be};
      avs_write <= w;
      avs_read <= !w;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      if (n >= 20) failures++;
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge mclk);
   endtask
   task complete_run;
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   initial begin
      repeat (5000) @(posedge mclk);
      failures++;
      complete_run;
   end
   initial begin
      {rstn, avs_read, avs_write, tx_request} = 4'h0;
      avs_address = 8'h00;
      avs_writedata = 32'h0;
      avs_byteenable = 4'h0;
      repeat (2) @(posedge mclk);
      rstn <= 1'b1;
      for (i = 0; i < 6; i++) begin
         bus(1'b0, adr[i], 8'h00, 1'b1);
         chk("reset", rst[i], q);
      end
      bus(1'b0, 8'h00, 8'h00, 1'b1);
      chk("unmapped", 0, q);
      $display("reset test done");
      for (i = 0; i < 5; i++) begin
         bus(1'b1, adr[i], 8'hFF, 1'b1);
         bus(1'b1, adr[i], 8'h00, 1'b0);
         bus(1'b0, adr[i], 8'h00, 1'b1);
         chk("readback", (i == 4) ? 8'h3F : 8'hFF, q);
      end
      $display("access test done");
      for (i = 0; i < 8; i++) begin
         bus(1'b1, 8'h98, {i[0], i[2:0], i[3:0]}, 1'b1);
         #1;
         chk("gain_db", db[i], receiver_gain_db);
         chk("rx_cfg", {i[0], i[2:0], i[3:0]},
            {level_detect_amp_en, receiver_gain_sel, level_detect_sensitivity});
         @(posedge mclk);
      end
      $display("receive test done");
      bus(1'b1, 8'h8C, 8'h35, 1'b1);
      bus(1'b1, 8'h9C, 8'h62, 1'b1);
      bus(1'b1, 8'hA0, 8'h15, 1'b1);
      for (i = 0; i < 16; i++) begin
         bus(1'b1, 8'hC0, i[7:0], 1'b1);
         #1;
         nx = (i[0] | i[1]) ? (i[2] ? 4'h2 : 4'h6) : (i[2] ? 4'h5 : 4'h3);
         chk("n_cond", nx | {i[3], 3'h0}, n_drive_cond);
         chk("p_cond", 6'h15 | {i[3], 5'h00}, p_drive_unmod);
         chk("ctrl", i[3:0] & 4'hB,
            {soft_power_down, 1'b0, antenna_driver_2, antenna_driver_1});
         @(posedge mclk);
      end
      bus(1'b0, 8'h9C, 8'h00, 1'b1);
      chk("stored", 8'h62, q);
      $display("conductance test done");
      for (i = 0; i < 3; i++) begin
         bus(1'b1, 8'h94, nv[i][7:0], 1'b1);
         chk("demod_sel", 0, demod_clock_source_sel);
         tx_request <= 1'b1;
         k = 0;
         do begin
            @(posedge mclk);
            tx_request <= 1'b0;
            #1;
            k++;
         end while (tx_send_go !== 1'b1 && k < 200);
         chk("tx_wait", nv[i] + 2, k);
         @(posedge mclk);
      end
      $display("transmit wait test done");
      complete_run;
   end
endmodule // rf_frontend_config_regs_tb_top
bind rfc_regs rfc_regs_properties rfc_regs_properties_inst (.*);
`default_nettype wire
